// ==== ffs_axi_slave.sv ====
// module: axi4-lite slave front end, one write and one read in flight
`timescale 1ns/100ps
`default_nettype none
module ffs_axi_slave (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire ffs_pkg::ffs_axi_req_t req,
   output var  ffs_pkg::ffs_axi_rsp_t rsp,
   output logic                       wr_stb,
   output logic [11:0]                wr_addr,
   output logic [31:0]                wr_data,
   output logic [3:0]                 wr_strb,
   input  wire logic                  wr_ok,
   output logic                       rd_stb,
   output logic [11:0]                rd_addr,
   input  wire logic [31:0]           rd_data,
   input  wire logic                  rd_ok
);
   typedef struct packed {
      logic        aw_have;
      logic [11:0] aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ffs_slv_state_t;

   ffs_slv_state_t st_ff;
   ffs_slv_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (req.awvalid && !st_ff.aw_have && !st_ff.bvalid) begin
         nxt_st.aw_have = 1'b1;
         nxt_st.aw_addr = req.awaddr;
      end
      if (req.wvalid && !st_ff.w_have && !st_ff.bvalid) begin
         nxt_st.w_have = 1'b1;
         nxt_st.w_data = req.wdata;
         nxt_st.w_strb = req.wstrb;
      end
      if (st_ff.aw_have && st_ff.w_have) begin
         nxt_st.aw_have = 1'b0;
         nxt_st.w_have = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = wr_ok ? ffs_pkg::FFS_RESP_OKAY : ffs_pkg::FFS_RESP_SLVERR;
      end
      if (st_ff.bvalid && req.bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (req.arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_data;
         nxt_st.rresp = rd_ok ? ffs_pkg::FFS_RESP_OKAY : ffs_pkg::FFS_RESP_SLVERR;
      end
      if (st_ff.rvalid && req.rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign wr_stb = ce && st_ff.aw_have && st_ff.w_have;
   assign wr_addr = st_ff.aw_addr;
   assign wr_data = st_ff.w_data;
   assign wr_strb = st_ff.w_strb;
   assign rd_stb = ce && req.arvalid && !st_ff.rvalid;
   assign rd_addr = req.araddr;

   always_comb begin
      rsp.awready = !st_ff.aw_have && !st_ff.bvalid;
      rsp.wready = !st_ff.w_have && !st_ff.bvalid;
      rsp.bvalid = st_ff.bvalid;
      rsp.bresp = st_ff.bresp;
      rsp.arready = !st_ff.rvalid;
      rsp.rvalid = st_ff.rvalid;
      rsp.rdata = st_ff.rdata;
      rsp.rresp = st_ff.rresp;
   end
endmodule : ffs_axi_slave
`default_nettype wire

// ==== ffs_flash_status.sv ====
// module: flash status register, request flags and flash interrupt request
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module ffs_flash_status (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire ffs_pkg::ffs_axi_req_t axi_req,
   output var  ffs_pkg::ffs_axi_rsp_t axi_rsp,
   input  wire ffs_pkg::ffs_seq_t     seq,
   output logic                       flash_irq,
   output logic                       cpu_rewrite_select,
   output logic                       array_access_block
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic ready_busy_flag;
      logic suspend_flag;
      logic erase_blank_error_flag;
      logic program_error_flag;
      logic lock_monitor_bit;
      logic access_error_request;
      logic ready_request;
      logic prev_busy;
      logic lock_pending;
      logic ready_irq_enable;
      logic access_error_irq_enable;
      logic command_error_irq_enable;
      logic cpu_rewrite_select;
      logic irq;
      logic block;
   } ffs_state_t;

   ffs_state_t st_ff;
   ffs_state_t nxt_st;

   logic        wr_stb;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        rd_stb;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic        rd_ok;
   logic        wr_ok;
   logic [7:0]  status_byte;
   logic [7:0]  control_byte;
   logic        wr_status;
   logic        wr_control;
   logic        ready_edge;

   // ************************************************
   // bus front end
   // ************************************************
   ffs_axi_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .req     (axi_req),
      .rsp     (axi_rsp),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_stb  (rd_stb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // ************************************************
   // read mux
   // ************************************************
   always_comb begin
      status_byte = 8'h00;
      status_byte[ffs_pkg::FFS_BIT_READY] = st_ff.ready_busy_flag;
      status_byte[ffs_pkg::FFS_BIT_SUSPEND] = st_ff.suspend_flag;
      status_byte[ffs_pkg::FFS_BIT_ERASE_ERR] = st_ff.erase_blank_error_flag;
      status_byte[ffs_pkg::FFS_BIT_PROG_ERR] = st_ff.program_error_flag;
      status_byte[3] = 1'b0;
      status_byte[ffs_pkg::FFS_BIT_LOCK] = st_ff.lock_monitor_bit;
      status_byte[ffs_pkg::FFS_BIT_ACCESS_ERR] = st_ff.access_error_request;
      status_byte[ffs_pkg::FFS_BIT_READY_REQ] = st_ff.ready_request;
      control_byte = 8'h00;
      control_byte[ffs_pkg::FFS_BIT_READY_IE] = st_ff.ready_irq_enable;
      control_byte[ffs_pkg::FFS_BIT_ACCERR_IE] = st_ff.access_error_irq_enable;
      control_byte[ffs_pkg::FFS_BIT_CMDERR_IE] = st_ff.command_error_irq_enable;
      control_byte[ffs_pkg::FFS_BIT_REWRITE] = st_ff.cpu_rewrite_select;
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (rd_addr[11:2] == ffs_pkg::FFS_STATUS_BYTE_ADDR[11:2]) begin
         rd_data = {24'h00_0000, status_byte};
      end else if (rd_addr[11:2] == ffs_pkg::FFS_CONTROL_BYTE_ADDR[11:2]) begin
         rd_data = {24'h00_0000, control_byte};
      end else begin
         rd_ok = 1'b0;
      end
   end

   assign wr_status = wr_stb && wr_strb[0] && (wr_addr[11:2] == ffs_pkg::FFS_STATUS_BYTE_ADDR[11:2]);
   assign wr_control = wr_stb && wr_strb[0] && (wr_addr[11:2] == ffs_pkg::FFS_CONTROL_BYTE_ADDR[11:2]);
   assign wr_ok = (wr_addr[11:2] == ffs_pkg::FFS_STATUS_BYTE_ADDR[11:2])
                  || (wr_addr[11:2] == ffs_pkg::FFS_CONTROL_BYTE_ADDR[11:2]);

   assign ready_edge = st_ff.prev_busy && !seq.busy;

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev_busy = seq.busy;
      nxt_st.ready_busy_flag = !seq.busy;
      nxt_st.suspend_flag = seq.suspended;
      nxt_st.program_error_flag = seq.program_error || seq.command_error;
      nxt_st.erase_blank_error_flag = seq.erase_error || seq.blank_error || seq.command_error;

      if (wr_control) begin
         nxt_st.ready_irq_enable = wr_data[ffs_pkg::FFS_BIT_READY_IE];
         nxt_st.access_error_irq_enable = wr_data[ffs_pkg::FFS_BIT_ACCERR_IE];
         nxt_st.command_error_irq_enable = wr_data[ffs_pkg::FFS_BIT_CMDERR_IE];
         nxt_st.cpu_rewrite_select = wr_data[ffs_pkg::FFS_BIT_REWRITE];
      end

      if (wr_status && !wr_data[ffs_pkg::FFS_BIT_READY_REQ]) begin
         nxt_st.ready_request = 1'b0;
      end
      if (wr_status && !wr_data[ffs_pkg::FFS_BIT_ACCESS_ERR]) begin
         nxt_st.access_error_request = 1'b0;
      end
      if (seq.clear_status_cmd) begin
         nxt_st.access_error_request = 1'b0;
      end

      // ready edge sets request, set beats clear
      if (ready_edge && st_ff.ready_irq_enable) begin
         nxt_st.ready_request = 1'b1;
      end
      if (st_ff.access_error_irq_enable && seq.busy
          && (seq.busy_area_access || seq.data_read_during_prog)) begin
         nxt_st.access_error_request = 1'b1;
      end
      if (st_ff.command_error_irq_enable && (seq.command_error || seq.erase_error
          || seq.blank_error || seq.program_error)) begin
         nxt_st.access_error_request = 1'b1;
      end

      if (seq.cmd_entered) begin
         nxt_st.lock_pending = seq.lock_affecting_cmd && seq.lock_read_cmd;
      end
      if (ready_edge && st_ff.lock_pending) begin
         nxt_st.lock_monitor_bit = seq.lock_status;
         nxt_st.lock_pending = 1'b0;
      end

      nxt_st.irq = nxt_st.ready_request || nxt_st.access_error_request;
      // blocked access gate for the array
      nxt_st.block = seq.busy && (seq.busy_area_access || seq.data_read_during_prog);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.ready_busy_flag <= ffs_pkg::FFS_STATUS_RESET[ffs_pkg::FFS_BIT_READY];
         st_ff.lock_monitor_bit <= ffs_pkg::FFS_LOCK_RESET;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign flash_irq = st_ff.irq;
   assign cpu_rewrite_select = st_ff.cpu_rewrite_select;
   assign array_access_block = st_ff.block;
endmodule : ffs_flash_status
`default_nettype wire

// ==== ffs_flash_status_props.sv ====
// checker: port relations of the flash status block
`timescale 1ns/100ps
`default_nettype none
module ffs_flash_status_props (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   input wire ffs_pkg::ffs_axi_req_t axi_req,
   input wire ffs_pkg::ffs_axi_rsp_t axi_rsp,
   input wire ffs_pkg::ffs_seq_t     seq,
   input wire logic                  flash_irq,
   input wire logic                  cpu_rewrite_select,
   input wire logic                  array_access_block
);
   logic st_rd_ff;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****
   // properties
   // ****
   // marks a read of the status byte
   always_ff @(posedge aclk) begin
      if (axi_req.arvalid && axi_rsp.arready) begin
         st_rd_ff <= (axi_req.araddr == ffs_pkg::FFS_STATUS_BYTE_ADDR);
      end
   end
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   // steady inputs, so read data has settled
   sequence s_calm_rd;
      $stable(seq) [*3] ##0 ($rose(axi_rsp.rvalid) && st_rd_ff);
   endsequence
   // both halves held one cycle, response the cycle after
   property p_b_answer; s_wr_take |-> ##2 axi_rsp.bvalid; endproperty
   property p_r_answer; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
   property p_ar_refuse; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
   property p_ready; s_calm_rd |-> axi_rsp.rdata[7] == !seq.busy; endproperty
   property p_susp; s_calm_rd |-> axi_rsp.rdata[6] == seq.suspended; endproperty
   property p_prog; s_calm_rd |-> axi_rsp.rdata[4] == (seq.program_error || seq.command_error); endproperty
   property p_erase;
      s_calm_rd |-> axi_rsp.rdata[5] == (seq.erase_error || seq.blank_error || seq.command_error);
   endproperty
   property p_irq; s_calm_rd |-> flash_irq == (axi_rsp.rdata[1] || axi_rsp.rdata[0]); endproperty
   property p_zero;
      $rose(axi_rsp.rvalid) && st_rd_ff |-> axi_rsp.rdata[31:8] == 24'h00_0000 && !axi_rsp.rdata[3];
   endproperty
   property p_block;
      seq.busy && (seq.busy_area_access || seq.data_read_during_prog) |=> array_access_block;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write response late");
   a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answer pending");
   a_r_answer: assert property (p_r_answer) else $error("read response late");
   a_ready: assert property (p_ready) else $error("ready bit wrong");
   a_susp: assert property (p_susp) else $error("suspend bit wrong");
   a_prog: assert property (p_prog) else $error("program error bit wrong");
   a_erase: assert property (p_erase) else $error("erase error bit wrong");
   a_irq: assert property (p_irq) else $error("interrupt request wrong");
   a_zero: assert property (p_zero) else $error("unused bits not zero");
   a_block: assert property (p_block) else $error("blocked access not flagged");
endmodule : ffs_flash_status_props
bind ffs_flash_status ffs_flash_status_props ffs_flash_status_props_i (.aclk(aclk), .aresetn(aresetn),
   .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp), .seq(seq), .flash_irq(flash_irq),
   .cpu_rewrite_select(cpu_rewrite_select), .array_access_block(array_access_block));
`default_nettype wire

// ==== ffs_flash_status_tb.sv ====
// testbench: register access, flag events and clearing of the flash status block
`timescale 1ns/100ps
`default_nettype none
module ffs_flash_status_tb;
   logic                   aclk;
   logic                   aresetn;
   ffs_pkg::ffs_axi_req_t  axi_req;
   ffs_pkg::ffs_axi_rsp_t  axi_rsp;
   ffs_pkg::ffs_seq_t      seq;
   logic                   flash_irq;
   logic                   cpu_rewrite_select;
   logic                   array_access_block;
   logic [31:0]            rd_d;
   logic [1:0]             rsp;
   logic [3:0]             e;
   int                     fails;
   int                     total_checks;
   localparam logic [11:0] ST = ffs_pkg::FFS_STATUS_BYTE_ADDR;
   localparam logic [11:0] CT = ffs_pkg::FFS_CONTROL_BYTE_ADDR;
   ffs_flash_status ffs_flash_status_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .seq(seq), .flash_irq(flash_irq), .cpu_rewrite_select(cpu_rewrite_select),
      .array_access_block(array_access_block));
   ffs_seq_model ffs_seq_model_i (.aclk(aclk), .seq(seq));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ****
   // tasks
   // ****
   function automatic logic [31:0] st(input logic [6:0] v);
      st = {24'h00_0000, v[6:3], 1'b0, v[2:0]};
   endfunction : st
   function automatic logic [31:0] ctl(input logic [2:0] v);
      ctl = '0;
      ctl[ffs_pkg::FFS_BIT_READY_IE] = v[2];
      ctl[ffs_pkg::FFS_BIT_ACCERR_IE] = v[1];
      ctl[ffs_pkg::FFS_BIT_CMDERR_IE] = v[0];
      ctl[ffs_pkg::FFS_BIT_REWRITE] = 1'b1;
   endfunction : ctl
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic chk_bit(input logic g, input logic x);
      chk({31'h0000_0000, g}, {31'h0000_0000, x});
   endtask : chk_bit
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      {axi_req.awaddr, axi_req.wdata, axi_req.wstrb} <= {a, d, 4'h1};
      {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'b111;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
         if (axi_rsp.bvalid) begin
            rsp = axi_rsp.bresp;
            axi_req.bready <= 1'b0;
            return;
         end
      end
      fails++;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      axi_req.araddr <= a;
      {axi_req.arvalid, axi_req.rready} <= 2'b11;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
         if (axi_rsp.rvalid) begin
            {rd_d, rsp} = {axi_rsp.rdata, axi_rsp.rresp};
            axi_req.rready <= 1'b0;
            return;
         end
      end
      fails++;
   endtask : rd
   // dummy read first, then clear, then read back
   task automatic clr(input logic [31:0] d);
      rd(ST);
      wr(ST, d);
      rd(ST);
   endtask : clr
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // ****
   // tests
   // ****
   initial begin
      {axi_req, aresetn, fails, total_checks} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ST);
      chk(rd_d, st(7'b1000100));
      rd(12'h0100);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, ffs_pkg::FFS_RESP_SLVERR});
      wr(12'h0100, 32'h0000_0000);
      chk({30'h0000_0000, rsp}, {30'h0000_0000, ffs_pkg::FFS_RESP_SLVERR});
      wr(ST, 32'h0000_00ff);
      rd(ST);
      chk(rd_d, st(7'b1000100));
      wr(CT, ctl(3'b100));
      rd(CT);
      chk(rd_d, ctl(3'b100));
      chk_bit(cpu_rewrite_select, 1'b1);
      fork
         ffs_seq_model_i.run(1'b0, 1'b1, 1'b0, 20);
         begin
            repeat (4) @(posedge aclk);
            ffs_seq_model_i.evt(3'b100);
            rd(ST);
            chk(rd_d, st(7'b0000100));
         end
      join
      rd(ST);
      chk(rd_d, st(7'b1000101));
      chk_bit(flash_irq, 1'b1);
      clr(32'h0000_0002);
      chk(rd_d, st(7'b1000100));
      chk_bit(flash_irq, 1'b0);
      ffs_seq_model_i.run(1'b0, 1'b1, 1'b1, 10);
      rd(ST);
      chk(rd_d, st(7'b1100101));
      clr(32'h0000_0002);
      wr(CT, ctl(3'b110));
      // access while ready must not raise the error request
      ffs_seq_model_i.evt(3'b100);
      rd(ST);
      chk(rd_d, st(7'b1100100));
      for (int i = 0; i < 2; i++) begin
         fork
            ffs_seq_model_i.run(1'b0, 1'b1, 1'b0, 12);
            begin
               repeat (4) @(posedge aclk);
               ffs_seq_model_i.evt(i == 0 ? 3'b100 : 3'b010);
            end
         join
         rd(ST);
         chk(rd_d, st(7'b1000111));
         if (i == 0) clr(32'h0000_0001);
         else ffs_seq_model_i.evt(3'b001);
         rd(ST);
         chk(rd_d, st(7'b1000101));
         clr(32'h0000_0000);
      end
      wr(CT, ctl(3'b001));
      for (int i = 0; i < 4; i++) begin
         e = 4'b1000 >> i;
         ffs_seq_model_i.err(e);
         rd(ST);
         chk(rd_d, st({2'b10, |e[2:0], e[3] | e[0], 3'b110}));
         chk_bit(flash_irq, 1'b1);
         ffs_seq_model_i.err(4'b0000);
         ffs_seq_model_i.evt(3'b001);
         rd(ST);
         chk(rd_d, st(7'b1000100));
      end
      wr(CT, ctl(3'b000));
      for (int i = 0; i < 3; i++) begin
         ffs_seq_model_i.run(i != 1, i != 0, 1'b0, 8);
         rd(ST);
         chk(rd_d, st({4'b1000, i == 2, 2'b00}));
      end
      wr(CT, 32'h0000_0000);
      rd(CT);
      chk_bit(cpu_rewrite_select, 1'b0);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end
endmodule : ffs_flash_status_tb
`default_nettype wire

// ==== ffs_pkg.sv ====
// package: constants, types and register map of the flash status flag block
// Behaviour
// - busy flag low during any sequencer activity
// - busy to ready sets ready request
// - all listed completions count as ready
// - software writes only clear ready request
// - busy area access sets access error
// - blocked reads undefined, blocked writes dropped
// - command errors also set access error
// - software writes only clear access error
// - clear status command clears access error
// - lock bit loaded when lock read ends
// - lock bit updated only by three commands
// - program error flag follows program error
// - erase flag follows erase/blank error
// - command error sets both error flags
// - suspend flag shows acknowledged suspend state
// - bit three reads zero always
`default_nettype none
package ffs_pkg;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [11:0] FFS_FLASH_STATUS_ADDR = 12'h01b2;
   localparam logic [11:0] FFS_FLASH_CONTROL0_ADDR = 12'h01b4;
   localparam logic [11:0] FFS_STATUS_BYTE_ADDR = 12'h06c8;
   localparam logic [11:0] FFS_CONTROL_BYTE_ADDR = 12'h06d0;
   localparam logic [7:0] FFS_STATUS_RESET = 8'h80;
   localparam logic [7:0] FFS_CONTROL_RESET = 8'h00;
   // lock bit is undefined after reset, start as not locked
   localparam logic FFS_LOCK_RESET = 1'b1;
   localparam int FFS_BIT_READY_REQ = 0;
   localparam int FFS_BIT_ACCESS_ERR = 1;
   localparam int FFS_BIT_LOCK = 2;
   localparam int FFS_BIT_PROG_ERR = 4;
   localparam int FFS_BIT_ERASE_ERR = 5;
   localparam int FFS_BIT_SUSPEND = 6;
   localparam int FFS_BIT_READY = 7;
   localparam int FFS_BIT_REWRITE = 1;
   localparam int FFS_BIT_CMDERR_IE = 5;
   localparam int FFS_BIT_ACCERR_IE = 6;
   localparam int FFS_BIT_READY_IE = 7;
   localparam logic [1:0] FFS_RESP_OKAY = 2'b00;
   localparam logic [1:0] FFS_RESP_SLVERR = 2'b10;

   // ************************************************
   // carriers
   // ************************************************
   typedef struct packed {
      logic busy;
      logic suspended;
      logic program_error;
      logic erase_error;
      logic blank_error;
      logic command_error;
      logic lock_read_cmd;
      logic lock_status;
      logic cmd_entered;
      logic lock_affecting_cmd;
      logic clear_status_cmd;
      logic busy_area_access;
      logic data_read_during_prog;
   } ffs_seq_t;

   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } ffs_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ffs_axi_rsp_t;
endpackage : ffs_pkg
`default_nettype wire

// ==== ffs_seq_model.sv ====
// partner model: flash sequencer events seen by the status block
`timescale 1ns/100ps
`default_nettype none
module ffs_seq_model (
   input  wire logic              aclk,
   output var  ffs_pkg::ffs_seq_t seq
);
   initial seq = '0;
   // busy spans command, ready ends it
   task automatic run(input logic lock_rd, input logic lk, input logic susp, input int n);
      @(posedge aclk);
      seq.cmd_entered <= 1'b1;
      seq.lock_affecting_cmd <= 1'b1;
      seq.lock_read_cmd <= lock_rd;
      seq.busy <= 1'b1;
      seq.suspended <= 1'b0;
      @(posedge aclk);
      seq.cmd_entered <= 1'b0;
      repeat (n) @(posedge aclk);
      seq.lock_status <= lk;
      seq.busy <= 1'b0;
      seq.suspended <= susp;
      repeat (3) @(posedge aclk);
   endtask : run
   task automatic err(input logic [3:0] e);
      @(posedge aclk);
      {seq.program_error, seq.erase_error, seq.blank_error, seq.command_error} <= e;
      repeat (3) @(posedge aclk);
   endtask : err
   task automatic evt(input logic [2:0] p);
      @(posedge aclk);
      {seq.busy_area_access, seq.data_read_during_prog, seq.clear_status_cmd} <= p;
      @(posedge aclk);
      {seq.busy_area_access, seq.data_read_during_prog, seq.clear_status_cmd} <= 3'b000;
      repeat (3) @(posedge aclk);
   endtask : evt
endmodule : ffs_seq_model
`default_nettype wire
